// ==== ilc_pkg.sv ====
// constants for the two-lane interpolator control block
package ilc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_ACC_ZERO = 8'hc0;
  localparam logic [7:0] OFF_ACC_ONE = 8'hc4;
  localparam logic [7:0] OFF_BASE_ZERO = 8'hc8;
  localparam logic [7:0] OFF_BASE_ONE = 8'hcc;
  localparam logic [7:0] OFF_BASE2 = 8'hd0;
  localparam logic [7:0] OFF_POP_LANE0 = 8'hd4;
  localparam logic [7:0] OFF_POP_LANE1 = 8'hd8;
  localparam logic [7:0] OFF_POP_FULL = 8'hdc;
  localparam logic [7:0] OFF_PEEK_LANE0 = 8'he0;
  localparam logic [7:0] OFF_PEEK_LANE1 = 8'he4;
  localparam logic [7:0] OFF_PEEK_FULL = 8'he8;
  localparam logic [7:0] OFF_LANE_ZERO_CONTROL = 8'hec;
  localparam logic [7:0] OFF_LANE_ONE_CONTROL = 8'hf0;
  localparam logic [7:0] OFF_ACC_ZERO_ADD = 8'hf4;
  localparam logic [7:0] OFF_ACC_ONE_ADD = 8'hf8;
  localparam logic [7:0] OFF_BASE_BOTH = 8'hfc;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int SHIFT_LSB = 0;
  localparam int MASK_LO_LSB = 5;
  localparam int MASK_HI_LSB = 10;
  localparam int SIGN_BIT = 15;
  localparam int CROSS_IN_BIT = 16;
  localparam int CROSS_RES_BIT = 17;
  localparam int RAW_BIT = 18;
  localparam int FORCE_LSB = 19;
  localparam int CLAMP_BIT = 22;
  localparam int OVF0_BIT = 23;
  localparam int OVF1_BIT = 24;
  localparam int OVF_ANY_BIT = 25;
  localparam int FORCE_DST_LSB = 28;
  localparam int ADD_W = 24;

  // ---------------------------------------------------------------
  // writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL0_WMASK = 32'h005fffff;
  localparam logic [31:0] CTRL1_WMASK = 32'h001fffff;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [31:0] ALL_ONES = 32'hffffffff;

  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ilc_pkg

// ==== ilc_lane.sv ====
// one lane: input select, shift, mask, sign extend, base add, overflow
`timescale 1ns/1ps
module ilc_lane (
  // accumulators
  input wire logic [31:0] own_accum_in,
  input wire logic [31:0] other_accum_in,
  // configuration
  input wire logic [31:0] ctrl_in,
  input wire logic [31:0] base_in,
  // results
  output logic [31:0] sel_out,
  output logic [31:0] masked_out,
  output logic [31:0] result_out,
  output logic overflow_out
);
  logic [4:0] shamt;
  logic [4:0] lo;
  logic [4:0] hi;
  logic [31:0] keep;
  logic [31:0] above;
  logic [31:0] plain;

  assign shamt = ctrl_in[ilc_pkg::SHIFT_LSB +: 5];
  assign lo = ctrl_in[ilc_pkg::MASK_LO_LSB +: 5];
  assign hi = ctrl_in[ilc_pkg::MASK_HI_LSB +: 5];
  // mux sits ahead of the raw bypass
  assign sel_out = ctrl_in[ilc_pkg::CROSS_IN_BIT] ? other_accum_in
                                                   : own_accum_in;
  assign above = ~(ilc_pkg::ALL_ONES >> (5'd31 - hi));
  assign keep = (ilc_pkg::ALL_ONES << lo) & ~above;
  assign plain = (sel_out >> shamt) & keep;
  // sign bit is the top passing bit of the mask
  assign masked_out = (ctrl_in[ilc_pkg::SIGN_BIT] && plain[hi]) ?
                      (plain | above) : plain;
  assign result_out = ctrl_in[ilc_pkg::RAW_BIT] ? (sel_out + base_in)
                      : (masked_out + base_in);
  assign overflow_out = |(own_accum_in & above);
endmodule : ilc_lane

// ==== ilc_top.sv ====
// interpolator lane control with axi4-lite register slave
`timescale 1ns/1ps
module ilc_top #(
  parameter bit HAS_CLAMP = 1'b1,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // write data channel
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // write response channel
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // read data channel
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] accum_reg [2];
  logic [31:0] base_reg [3];
  logic [31:0] ctrl_reg [2];
  logic [31:0] sel [2];
  logic [31:0] masked [2];
  logic [31:0] lane_res [2];
  logic ovf [2];
  logic [31:0] res0;
  logic [31:0] full_res;
  logic [31:0] read_val [2];

  // ---------------------------------------------------------------
  // lanes
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_lane
    ilc_lane u_lane (
      .own_accum_in(accum_reg[i]),
      .other_accum_in(accum_reg[1-i]),
      .ctrl_in(ctrl_reg[i]),
      .base_in(base_reg[i]),
      .sel_out(sel[i]),
      .masked_out(masked[i]),
      .result_out(lane_res[i]),
      .overflow_out(ovf[i])
    );
  end

  logic clamp_on;
  logic sign0;
  assign clamp_on = HAS_CLAMP && ctrl_reg[0][ilc_pkg::CLAMP_BIT];
  assign sign0 = ctrl_reg[0][ilc_pkg::SIGN_BIT];

  always_comb begin
    res0 = lane_res[0];
    if (clamp_on) begin
      res0 = masked[0];
      if (sign0) begin
        if ($signed(masked[0]) < $signed(base_reg[0])) begin
          res0 = base_reg[0];
        end else if ($signed(masked[0]) > $signed(base_reg[1])) begin
          res0 = base_reg[1];
        end
      end else begin
        if (masked[0] < base_reg[0]) begin
          res0 = base_reg[0];
        end else if (masked[0] > base_reg[1]) begin
          res0 = base_reg[1];
        end
      end
    end
  end

  // full path ignores raw bypass and clamp
  assign full_res = masked[0] + masked[1] + base_reg[2];

  // forced bits exist only on the bus view
  assign read_val[0] = res0 | {2'h0,
      ctrl_reg[0][ilc_pkg::FORCE_LSB +: 2], 28'h0};
  assign read_val[1] = lane_res[1] | {2'h0,
      ctrl_reg[1][ilc_pkg::FORCE_LSB +: 2], 28'h0};

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic wr_fire;
  logic ar_fire;

  // both halves held and no response pending
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held_reg <= 1'b0;
      s_axi_awready_out <= 1'b1;
      wr_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_reg <= 1'b1;
      s_axi_awready_out <= 1'b0;
      wr_addr_reg <= {s_axi_awaddr_in[7:2], 2'h0};
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_held_reg <= 1'b0;
      s_axi_wready_out <= 1'b1;
      wr_data_reg <= ilc_pkg::DATA_RESET;
      wr_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_reg <= 1'b1;
      s_axi_wready_out <= 1'b0;
      wr_data_reg <= s_axi_wdata_in;
      wr_strb_reg <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end
  end

  logic wr_known;
  assign wr_known = (wr_addr_reg >= ilc_pkg::OFF_ACC_ZERO) &&
                    (wr_addr_reg <= ilc_pkg::OFF_BASE_BOTH);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= ilc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_known ? ilc_pkg::RESP_OKAY
                                  : ilc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] half(input logic [15:0] h,
                                       input logic sgn);
    return sgn ? {{16{h[15]}}, h} : {16'h0, h};
  endfunction : half

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic pop_hit;
  logic [31:0] ctrl0_view;

  assign rd_addr = {s_axi_araddr_in[7:2], 2'h0};
  assign pop_hit = ar_fire && ((rd_addr == ilc_pkg::OFF_POP_LANE0) ||
                   (rd_addr == ilc_pkg::OFF_POP_LANE1) ||
                   (rd_addr == ilc_pkg::OFF_POP_FULL));
  assign ctrl0_view = {6'h0, ovf[0] | ovf[1], ovf[1], ovf[0],
                       ctrl_reg[0][22:0]};

  always_comb begin
    rd_data = ilc_pkg::DATA_RESET;
    rd_err = 1'b0;
    if (rd_addr == ilc_pkg::OFF_ACC_ZERO) begin
      rd_data = accum_reg[0];
    end else if (rd_addr == ilc_pkg::OFF_ACC_ONE) begin
      rd_data = accum_reg[1];
    end else if (rd_addr == ilc_pkg::OFF_BASE_ZERO) begin
      rd_data = base_reg[0];
    end else if (rd_addr == ilc_pkg::OFF_BASE_ONE) begin
      rd_data = base_reg[1];
    end else if (rd_addr == ilc_pkg::OFF_BASE2) begin
      rd_data = base_reg[2];
    end else if (rd_addr == ilc_pkg::OFF_POP_LANE0 ||
                 rd_addr == ilc_pkg::OFF_PEEK_LANE0) begin
      rd_data = read_val[0];
    end else if (rd_addr == ilc_pkg::OFF_POP_LANE1 ||
                 rd_addr == ilc_pkg::OFF_PEEK_LANE1) begin
      rd_data = read_val[1];
    end else if (rd_addr == ilc_pkg::OFF_POP_FULL ||
                 rd_addr == ilc_pkg::OFF_PEEK_FULL) begin
      rd_data = full_res;
    end else if (rd_addr == ilc_pkg::OFF_LANE_ZERO_CONTROL) begin
      rd_data = ctrl0_view;
    end else if (rd_addr == ilc_pkg::OFF_LANE_ONE_CONTROL) begin
      rd_data = ctrl_reg[1];
    end else if (rd_addr == ilc_pkg::OFF_ACC_ZERO_ADD) begin
      rd_data = {8'h0, masked[0][ilc_pkg::ADD_W-1:0]};
    end else if (rd_addr == ilc_pkg::OFF_ACC_ONE_ADD) begin
      rd_data = {8'h0, masked[1][ilc_pkg::ADD_W-1:0]};
    end else if (rd_addr == ilc_pkg::OFF_BASE_BOTH) begin
      rd_data = ilc_pkg::DATA_RESET;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= ilc_pkg::DATA_RESET;
      s_axi_rresp_out <= ilc_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_data;
      s_axi_rresp_out <= rd_err ? ilc_pkg::RESP_SLVERR
                                : ilc_pkg::RESP_OKAY;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // datapath registers
  // ---------------------------------------------------------------
  // a bus write in the same cycle as a pop wins on that accumulator
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accum_reg[0] <= ilc_pkg::DATA_RESET;
      accum_reg[1] <= ilc_pkg::DATA_RESET;
    end else begin
      if (pop_hit) begin
        accum_reg[0] <= ctrl_reg[0][ilc_pkg::CROSS_RES_BIT] ? lane_res[1]
                                                            : res0;
        accum_reg[1] <= ctrl_reg[1][ilc_pkg::CROSS_RES_BIT] ? res0
                                                            : lane_res[1];
      end
      if (wr_fire) begin
        if (wr_addr_reg == ilc_pkg::OFF_ACC_ZERO) begin
          accum_reg[0] <= merge(accum_reg[0], wr_data_reg, wr_strb_reg);
        end else if (wr_addr_reg == ilc_pkg::OFF_ACC_ONE) begin
          accum_reg[1] <= merge(accum_reg[1], wr_data_reg, wr_strb_reg);
        end else if (wr_addr_reg == ilc_pkg::OFF_ACC_ZERO_ADD) begin
          accum_reg[0] <= accum_reg[0] +
                          {8'h0, wr_data_reg[ilc_pkg::ADD_W-1:0]};
        end else if (wr_addr_reg == ilc_pkg::OFF_ACC_ONE_ADD) begin
          accum_reg[1] <= accum_reg[1] +
                          {8'h0, wr_data_reg[ilc_pkg::ADD_W-1:0]};
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_reg[0] <= ilc_pkg::DATA_RESET;
      base_reg[1] <= ilc_pkg::DATA_RESET;
      base_reg[2] <= ilc_pkg::DATA_RESET;
    end else if (wr_fire) begin
      if (wr_addr_reg == ilc_pkg::OFF_BASE_ZERO) begin
        base_reg[0] <= merge(base_reg[0], wr_data_reg, wr_strb_reg);
      end else if (wr_addr_reg == ilc_pkg::OFF_BASE_ONE) begin
        base_reg[1] <= merge(base_reg[1], wr_data_reg, wr_strb_reg);
      end else if (wr_addr_reg == ilc_pkg::OFF_BASE2) begin
        base_reg[2] <= merge(base_reg[2], wr_data_reg, wr_strb_reg);
      end else if (wr_addr_reg == ilc_pkg::OFF_BASE_BOTH) begin
        base_reg[0] <= half(wr_data_reg[15:0], sign0);
        base_reg[1] <= half(wr_data_reg[31:16],
                            ctrl_reg[1][ilc_pkg::SIGN_BIT]);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg[0] <= ilc_pkg::CTRL_RESET;
      ctrl_reg[1] <= ilc_pkg::CTRL_RESET;
    end else if (wr_fire) begin
      if (wr_addr_reg == ilc_pkg::OFF_LANE_ZERO_CONTROL) begin
        // clamp bit stores only on the first instance, and only with HAS_CLAMP set
        ctrl_reg[0] <= merge(ctrl_reg[0], wr_data_reg, wr_strb_reg) &
                       (HAS_CLAMP ? ilc_pkg::CTRL0_WMASK
                                  : ilc_pkg::CTRL1_WMASK);
      end else if (wr_addr_reg == ilc_pkg::OFF_LANE_ONE_CONTROL) begin
        ctrl_reg[1] <= merge(ctrl_reg[1], wr_data_reg, wr_strb_reg) &
                       ilc_pkg::CTRL1_WMASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // reference overflow, worked out apart from the lane logic
  logic ovf0_ref;
  logic ovf1_ref;
  assign ovf0_ref = |(accum_reg[0] & ~(ilc_pkg::ALL_ONES >>
      (5'd31 - ctrl_reg[0][ilc_pkg::MASK_HI_LSB +: 5])));
  assign ovf1_ref = |(accum_reg[1] & ~(ilc_pkg::ALL_ONES >>
      (5'd31 - ctrl_reg[1][ilc_pkg::MASK_HI_LSB +: 5])));

  a_any_overflow_read: assert property (
    ar_fire && rd_addr == ilc_pkg::OFF_LANE_ZERO_CONTROL |=>
    s_axi_rdata_out[ilc_pkg::OVF_ANY_BIT] ==
    (s_axi_rdata_out[ilc_pkg::OVF0_BIT] | s_axi_rdata_out[ilc_pkg::OVF1_BIT]))
    else $error("combined overflow bit wrong");
  a_lane_one_overflow: assert property (
    ar_fire && rd_addr == ilc_pkg::OFF_LANE_ZERO_CONTROL |=>
    s_axi_rdata_out[ilc_pkg::OVF1_BIT] == $past(ovf1_ref))
    else $error("lane one overflow wrong");
  a_lane_zero_overflow: assert property (
    ar_fire && rd_addr == ilc_pkg::OFF_LANE_ZERO_CONTROL |=>
    s_axi_rdata_out[ilc_pkg::OVF0_BIT] == $past(ovf0_ref))
    else $error("lane zero overflow wrong");
  a_clamp_unsigned: assert property (
    clamp_on && !sign0 && base_reg[0] <= base_reg[1] |->
    res0 >= base_reg[0] && res0 <= base_reg[1])
    else $error("unsigned clamp out of range");
  a_clamp_signed: assert property (
    clamp_on && sign0 && $signed(base_reg[0]) <= $signed(base_reg[1]) |->
    $signed(res0) >= $signed(base_reg[0]) &&
    $signed(res0) <= $signed(base_reg[1]))
    else $error("signed clamp out of range");
  a_clamp_absent: assert property (
    !HAS_CLAMP |-> !ctrl_reg[0][ilc_pkg::CLAMP_BIT])
    else $error("clamp stored on first instance");
  a_force_bits_read: assert property (
    ar_fire && (rd_addr == ilc_pkg::OFF_POP_LANE0 ||
    rd_addr == ilc_pkg::OFF_PEEK_LANE0) |=>
    (s_axi_rdata_out[29:28] & $past(ctrl_reg[0][20:19])) ==
    $past(ctrl_reg[0][20:19]))
    else $error("force bits missing on read");
  a_pop_unforced: assert property (
    pop_hit && !wr_fire && !ctrl_reg[0][ilc_pkg::CROSS_RES_BIT] |=>
    accum_reg[0] == $past(res0))
    else $error("pop wrote back forced value");
  a_raw_bypass: assert property (
    ctrl_reg[0][ilc_pkg::RAW_BIT] && !clamp_on |->
    res0 == sel[0] + base_reg[0])
    else $error("raw bypass not applied");
  a_cross_result: assert property (
    pop_hit && !wr_fire && ctrl_reg[0][ilc_pkg::CROSS_RES_BIT] |=>
    accum_reg[0] == $past(lane_res[1]))
    else $error("cross result not popped");
  a_peek_no_change: assert property (
    ar_fire && !pop_hit && !wr_fire |=>
    $stable(accum_reg[0]) && $stable(accum_reg[1]))
    else $error("peek changed accumulators");
  a_read_answer: assert property (
    ar_fire |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");

  c_pop_read: cover property (pop_hit);
  c_clamp_active: cover property (clamp_on && res0 != masked[0]);
  c_write_done: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_overflow_seen: cover property (ovf[0] && ovf[1]);

endmodule : ilc_top

// ==== ilc_axi_master.sv ====
// axi4-lite master model standing in for the processor core
`timescale 1ns/1ps
module ilc_axi_master (
  // clock
  input wire logic clk_in,
  // write side
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic bvalid_in,
  output logic bready_out,
  // read side
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // ---------------------------------------------------------------
  // idle state and bus tasks
  // ---------------------------------------------------------------
  initial begin
    awaddr_out = 8'h00;
    awvalid_out = 1'b0;
    wdata_out = 32'h0;
    wstrb_out = 4'hf;
    wvalid_out = 1'b0;
    bready_out = 1'b0;
    araddr_out = 8'h00;
    arvalid_out = 1'b0;
    rready_out = 1'b0;
  end

  // payload is scrambled once taken, so stale values never look valid
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
      if (bvalid_in) begin
        bready_out <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
      end
    end while (!rvalid_in);
    rready_out <= 1'b0;
    d = rdata_in;
    r = rresp_in;
  endtask : bus_rd
endmodule : ilc_axi_master

// ==== tb_top.sv ====
// self-checking bench for the interpolator lane control block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb_top;
  // ---------------------------------------------------------------
  // wires and bookkeeping
  // ---------------------------------------------------------------
  logic core_clk_in;
  logic nrst_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [31:0] rdata_nc;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int error_cnt = 0;
  int check_count = 0;
  logic [31:0] cl_ctrl [3] = '{32'h401c00, 32'h401c00, 32'h409c00};
  logic [31:0] cl_acc [3] = '{32'h80, 32'h5, 32'h80};
  logic [31:0] cl_exp [3] = '{32'h40, 32'h10, 32'h10};

  ilc_top #(.HAS_CLAMP(1'b1), .ADDR_W(8)) i_ilc_top (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));

  ilc_axi_master i_ilc_axi_master (
    .clk_in(core_clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
    .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
    .rvalid_in(rvalid), .rready_out(rready));

  // variant without clamp on the same bus; its handshake runs in step
  ilc_top #(.HAS_CLAMP(1'b0), .ADDR_W(8)) i_ilc_top_nc (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(), .s_axi_bresp_out(),
    .s_axi_bvalid_out(), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(), .s_axi_rdata_out(rdata_nc),
    .s_axi_rresp_out(), .s_axi_rvalid_out(),
    .s_axi_rready_in(rready));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ilc_axi_master.bus_wr(a, d);
    `CHK(bresp, ilc_pkg::RESP_OKAY)
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    i_ilc_axi_master.bus_rd(a, d, r);
    `CHK(d, e)
    `CHK(r, ilc_pkg::RESP_OKAY)
  endtask : rd_chk

  // hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk_in);
    error_cnt++;
    final_report();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    nrst_in = 1'b0;
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rd_chk(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h0);
    rd_chk(ilc_pkg::OFF_LANE_ONE_CONTROL, 32'h0);
    i_ilc_axi_master.bus_rd(8'h10, rv, rr);
    `CHK(rr, ilc_pkg::RESP_SLVERR)
    `CHK(rv, 32'h0)
    i_ilc_axi_master.bus_wr(8'h10, 32'h1);
    `CHK(bresp, ilc_pkg::RESP_SLVERR)
    // shift 4, mask 11:4
    wr(ilc_pkg::OFF_ACC_ZERO, 32'h12345678);
    wr(ilc_pkg::OFF_BASE_ZERO, 32'h100);
    wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h2c84);
    rd_chk(ilc_pkg::OFF_PEEK_LANE0, 32'h660);
    rd_chk(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h02802c84);
    rd_chk(ilc_pkg::OFF_PEEK_LANE0, 32'h660);
    rd_chk(ilc_pkg::OFF_ACC_ZERO, 32'h12345678);
    // forced top bits stay off the datapath
    wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h182c84);
    wr(ilc_pkg::OFF_BASE_ONE, 32'h50);
    wr(ilc_pkg::OFF_BASE2, 32'h7);
    rd_chk(ilc_pkg::OFF_PEEK_FULL, 32'h567);
    rd_chk(ilc_pkg::OFF_POP_LANE0, 32'h30000660);
    rd_chk(ilc_pkg::OFF_ACC_ZERO, 32'h660);
    rd_chk(ilc_pkg::OFF_ACC_ONE, 32'h50);
    rd_chk(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h03182c84);
    // raw add and cross feeding
    wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h40000);
    rd_chk(ilc_pkg::OFF_PEEK_LANE0, 32'h760);
    rd_chk(ilc_pkg::OFF_PEEK_FULL, 32'h7);
    wr(ilc_pkg::OFF_LANE_ONE_CONTROL, 32'h50000);
    rd_chk(ilc_pkg::OFF_PEEK_LANE1, 32'h6b0);
    wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h60000);
    rd_chk(ilc_pkg::OFF_POP_LANE1, 32'h6b0);
    rd_chk(ilc_pkg::OFF_ACC_ZERO, 32'h6b0);
    // signed lanes, mask 7:0
    wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h9c00);
    wr(ilc_pkg::OFF_ACC_ZERO, 32'h80);
    rd_chk(ilc_pkg::OFF_PEEK_LANE0, 32'h80);
    // add takes only the low 24 bits; its read skips the base
    wr(ilc_pkg::OFF_ACC_ZERO_ADD, 32'hab000010);
    rd_chk(ilc_pkg::OFF_ACC_ZERO, 32'h90);
    rd_chk(ilc_pkg::OFF_ACC_ZERO_ADD, 32'h00ffff90);
    wr(ilc_pkg::OFF_LANE_ONE_CONTROL, 32'h9c00);
    wr(ilc_pkg::OFF_ACC_ONE, 32'hff);
    rd_chk(ilc_pkg::OFF_PEEK_LANE1, 32'h4f);
    // paired base write sign-extends each half per lane
    wr(ilc_pkg::OFF_BASE_BOTH, 32'hff00ff80);
    rd_chk(ilc_pkg::OFF_BASE_ZERO, 32'hffffff80);
    rd_chk(ilc_pkg::OFF_BASE_ONE, 32'hffffff00);
    // clamp above, below, and signed below
    wr(ilc_pkg::OFF_BASE_ZERO, 32'h10);
    wr(ilc_pkg::OFF_BASE_ONE, 32'h40);
    for (int i = 0; i < 3; i++) begin
      wr(ilc_pkg::OFF_LANE_ZERO_CONTROL, cl_ctrl[i]);
      wr(ilc_pkg::OFF_ACC_ZERO, cl_acc[i]);
      rd_chk(ilc_pkg::OFF_PEEK_LANE0, cl_exp[i]);
    end
    rd_chk(ilc_pkg::OFF_LANE_ZERO_CONTROL, 32'h409c00);
    `CHK(rdata_nc, 32'h00009c00)
    final_report();
  end
endmodule : tb_top
